// File: hdl/lsr_limit_status.sv
`timescale 1ns/1ps

// Functional notes
// - bit0 reg one follows remote one window
// - remote one bit set on alarm engage
// - remote one bit set on alarm release
// - bit1 follows remote two, or input nine
// - remote two bit set on engage, release
// - bit2 follows standby supply window
// - bit3 follows main 3.3 supply window
// - bit4 follows +5 supply window
// - bit5 follows core supply window
// - bit6 follows +12 supply window
// - bit7 follows -12 supply window
// - reg two bit n: analog input n
// - reg three bit n: fan n above high
// - three read-only bytes, reset zero
// - mask gates alert, not status bits
module lsr_limit_status
  import lsr_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              cmp_valid,
  input  wire logic [CH_W-1:0]   cmp_chan,
  input  wire logic [TEMP_W-1:0] cmp_value,
  input  wire logic              cmp_above_hi,
  input  wire logic              cmp_below_lo,
  input  wire logic              remote_temp_two_volt_mode,
  input  wire logic [TEMP_W-1:0] thermal_limit_one,
  input  wire logic [TEMP_W-1:0] thermal_limit_two,
  input  wire logic [NCH-1:0]    int_mask,
  input  wire logic              rd_req,
  input  wire logic [7:0]        rd_addr,
  output logic      [STAT_W-1:0] rd_data_q,
  output logic                   rd_ack_q,
  output logic                   alert_q,
  output logic      [1:0]        thermal_alarm_q
);

  // one-hot status bit for a channel code, zero when out of range
  function automatic logic [NCH-1:0] chan_onehot(input logic [CH_W-1:0] ch);
    logic [NCH-1:0] oh;
    oh = '0;
    if (ch <= CH_LAST_STATUS) begin
      oh[ch] = 1'b1;
    end
    return oh;
  endfunction : chan_onehot

  // {engage, release} of thermal alarm mode for one reading
  function automatic logic [1:0] alarm_step(
    input logic              active,
    input logic [TEMP_W-1:0] value,
    input logic [TEMP_W-1:0] limit
  );
    logic signed [TEMP_W:0] v;
    logic signed [TEMP_W:0] l;
    v = $signed({value[TEMP_W-1], value});
    l = $signed({limit[TEMP_W-1], limit});
    alarm_step = {!active && (v > l),
                  active && (v <= l - ALARM_HYST_DEGC)};
  endfunction : alarm_step

  logic [NCH-1:0]    status;
  logic [NCH-1:0]    upd_en;
  logic [NCH-1:0]    upd_val;
  logic [NCH-1:0]    evt_set;
  logic [STAT_W-1:0] status_one;
  logic [STAT_W-1:0] status_two;
  logic [STAT_W-1:0] status_three;
  logic [1:0]        thermal_alarm_d;
  logic              alert_d;
  logic [STAT_W-1:0] rd_sel;

  wire logic is_fan   = (cmp_chan >= CH_FAN_BASE) &&
                        (cmp_chan < CH_ANALOG_NINE);
  wire logic is_nine  = (cmp_chan == CH_ANALOG_NINE);
  wire logic is_rt2   = (cmp_chan == CH_REMOTE_TEMP_TWO);
  wire logic volt     = remote_temp_two_volt_mode;

  wire logic out_win  = cmp_above_hi || (cmp_below_lo && !is_fan);

  wire logic [CH_W-1:0] eff_chan = is_nine ? CH_REMOTE_TEMP_TWO : cmp_chan;
  wire logic src_ok   = is_nine ? volt : !(is_rt2 && volt);

  wire logic hit_one  = cmp_valid && (cmp_chan == CH_REMOTE_TEMP_ONE);
  wire logic hit_two  = cmp_valid && is_rt2 && !volt;

  wire logic [1:0] step_one = alarm_step(thermal_alarm_q[0], cmp_value,
                                         thermal_limit_one);
  wire logic [1:0] step_two = alarm_step(thermal_alarm_q[1], cmp_value,
                                         thermal_limit_two);
  wire logic [1:0] engage   = {hit_two && step_two[1],
                               hit_one && step_one[1]};
  wire logic [1:0] release_ = {hit_two && step_two[0],
                               hit_one && step_one[0]};

  assign upd_en  = (cmp_valid && src_ok) ? chan_onehot(eff_chan) : '0;
  assign upd_val = {NCH{out_win}};

  assign evt_set = {{(NCH-2){1'b0}}, engage | release_};

  assign thermal_alarm_d = (thermal_alarm_q | engage) & ~release_;

  assign alert_d = |(status & ~int_mask);

  assign rd_sel = (rd_addr == ADDR_STATUS_ONE)   ? status_one   :
                  (rd_addr == ADDR_STATUS_TWO)   ? status_two   :
                  (rd_addr == ADDR_STATUS_THREE) ? status_three :
                  RD_UNMAPPED;

  assign status = {status_three, status_two, status_one};

  lsr_status_byte u_status_one (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .upd_en   (upd_en[7:0]),
    .upd_val  (upd_val[7:0]),
    .evt_set  (evt_set[7:0]),
    .status_q (status_one)
  );

  lsr_status_byte u_status_two (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .upd_en   (upd_en[15:8]),
    .upd_val  (upd_val[15:8]),
    .evt_set  (evt_set[15:8]),
    .status_q (status_two)
  );

  lsr_status_byte u_status_three (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .upd_en   (upd_en[23:16]),
    .upd_val  (upd_val[23:16]),
    .evt_set  (evt_set[23:16]),
    .status_q (status_three)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      thermal_alarm_q <= 2'h0;
      alert_q         <= 1'b0;
      rd_data_q       <= STATUS_RST;
      rd_ack_q        <= 1'b0;
    end else begin
      thermal_alarm_q <= thermal_alarm_d;
      alert_q         <= alert_d;
      rd_data_q       <= rd_req ? rd_sel : rd_data_q;
      rd_ack_q        <= rd_req;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_rt1_out_window : assert property (
    hit_one && out_win |=> status[0]
  ) else $error("remote one out of window not flagged");

  a_rt1_in_window : assert property (
    hit_one && !out_win && !engage[0] && !release_[0] |=> !status[0]
  ) else $error("remote one in window not cleared");

  a_engage_flags : assert property (
    engage[0] |=> status[0] && thermal_alarm_q[0]
  ) else $error("remote one engage not flagged");

  a_release_flags : assert property (
    release_[0] |=> status[0] && !thermal_alarm_q[0]
  ) else $error("remote one release not flagged");

  a_nine_substitute : assert property (
    cmp_valid && is_nine && volt |=> status[1] == $past(out_win)
  ) else $error("input nine not routed to bit one");

  a_rt2_alarm_set : assert property (
    (engage[1] || release_[1]) |=> status[1]
  ) else $error("remote two alarm change not flagged");

  a_supply_bits : assert property (
    cmp_valid && cmp_chan >= CH_STANDBY_SUPPLY &&
    cmp_chan <= CH_MINUS12_SUPPLY
    |=> status[$past(cmp_chan)] == $past(out_win)
  ) else $error("supply status bit wrong");

  a_analog_bits : assert property (
    cmp_valid && cmp_chan >= CH_ANALOG_BASE && cmp_chan < CH_FAN_BASE
    |=> status[$past(cmp_chan)] == $past(cmp_above_hi || cmp_below_lo)
  ) else $error("analog status bit wrong");

  a_fan_high_only : assert property (
    cmp_valid && is_fan |=> status[$past(cmp_chan)] == $past(cmp_above_hi)
  ) else $error("fan status bit wrong");

  a_read_status : assert property (
    rd_req && rd_addr == ADDR_STATUS_THREE
    |=> rd_ack_q && rd_data_q == $past(status_three)
  ) else $error("status three read wrong");

  a_ack_single : assert property (
    !rd_req |=> !rd_ack_q
  ) else $error("read acknowledge without a request");

  a_reset_zero : assert property (disable iff (1'b0)
    rst |=> status == '0 && !alert_q && !rd_ack_q
  ) else $error("reset did not clear status");

  a_hold_stable : assert property (
    !cmp_valid ##1 !cmp_valid |=> $stable(status)
  ) else $error("status changed without a result");

  a_mask_alert : assert property (
    ##1 alert_q == |($past(status) & ~$past(int_mask))
  ) else $error("alert does not follow masked status");

  c_engage   : cover property (engage[0] ##[1:50] release_[0]);
  c_rt2_alarm: cover property (engage[1]);
  c_fan_set  : cover property (cmp_valid && is_fan && cmp_above_hi);
  c_read_one : cover property (rd_req && rd_addr == ADDR_STATUS_ONE);
  c_alert    : cover property (!alert_q ##1 alert_q);

endmodule : lsr_limit_status

// File: pkg/lsr_pkg.sv
package lsr_pkg;

  // widths
  localparam int STAT_W = 8;
  localparam int NCH    = 24;
  localparam int CH_W   = 5;
  localparam int TEMP_W = 8;

  // register addresses on the serial management port
  localparam logic [7:0] ADDR_STATUS_ONE   = 8'h20;
  localparam logic [7:0] ADDR_STATUS_TWO   = 8'h21;
  localparam logic [7:0] ADDR_STATUS_THREE = 8'h22;

  // reset and unmapped read values
  localparam logic [STAT_W-1:0] STATUS_RST  = 8'h00;
  localparam logic [STAT_W-1:0] RD_UNMAPPED = 8'h00;

  // channel codes; codes 0..23 equal the bit index in the 24-bit status
  localparam logic [CH_W-1:0] CH_REMOTE_TEMP_ONE = 5'h00;
  localparam logic [CH_W-1:0] CH_REMOTE_TEMP_TWO = 5'h01;
  localparam logic [CH_W-1:0] CH_STANDBY_SUPPLY  = 5'h02;
  localparam logic [CH_W-1:0] CH_MAIN_SUPPLY     = 5'h03;
  localparam logic [CH_W-1:0] CH_PLUS5_SUPPLY    = 5'h04;
  localparam logic [CH_W-1:0] CH_CORE_SUPPLY     = 5'h05;
  localparam logic [CH_W-1:0] CH_PLUS12_SUPPLY   = 5'h06;
  localparam logic [CH_W-1:0] CH_MINUS12_SUPPLY  = 5'h07;
  localparam logic [CH_W-1:0] CH_ANALOG_BASE     = 5'h08;
  localparam logic [CH_W-1:0] CH_FAN_BASE        = 5'h10;
  localparam logic [CH_W-1:0] CH_ANALOG_NINE     = 5'h18;
  localparam logic [CH_W-1:0] CH_LAST_STATUS     = 5'h17;

  // thermal alarm release hysteresis, degrees C (1 degree per lsb)
  localparam logic signed [TEMP_W:0] ALARM_HYST_DEGC = 9'sh005;

endpackage : lsr_pkg

// File: hdl/lsr_status_byte.sv
`timescale 1ns/1ps

module lsr_status_byte
  import lsr_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [STAT_W-1:0] upd_en,
  input  wire logic [STAT_W-1:0] upd_val,
  input  wire logic [STAT_W-1:0] evt_set,
  output logic      [STAT_W-1:0] status_q
);

  logic [STAT_W-1:0] status_d;

  // hold until next result
  // event set wins over a clearing result in the same cycle
  assign status_d = evt_set | (upd_en & upd_val) | (~upd_en & status_q);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  a_evt_wins_set : assert property (
    @(posedge clk_sys) disable iff (rst)
    (evt_set != 8'h00) |=> ((status_q & $past(evt_set)) == $past(evt_set))
  ) else $error("event set lost in status byte");

endmodule : lsr_status_byte

// File: tb/lsr_host_model.sv
`timescale 1ns/1ps

module lsr_host_model
  import lsr_pkg::*;
(
  input  wire logic              clk_sys,
  output logic                   rd_req,
  output logic      [7:0]        rd_addr,
  input  wire logic [STAT_W-1:0] rd_data_q,
  input  wire logic              rd_ack_q
);
  initial begin
    rd_req  = 1'b0;
    rd_addr = 8'h00;
  end

  task automatic read(input logic [7:0] a, output logic [STAT_W-1:0] d);
    @(posedge clk_sys);
    rd_req  <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_req  <= 1'b0;
    rd_addr <= ~a;
    @(posedge clk_sys);
    // answer must stand exactly one cycle after the taken edge
    d = (rd_ack_q === 1'b1) ? rd_data_q : 'x;
  endtask : read
endmodule : lsr_host_model

// File: tb/test_lsr_limit_status.sv
`timescale 1ns/1ps

module test_lsr_limit_status
  import lsr_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              cmp_valid = 1'b0;
  logic [CH_W-1:0]   cmp_chan = '0;
  logic [TEMP_W-1:0] cmp_value = '0;
  logic              cmp_above_hi = 1'b0;
  logic              cmp_below_lo = 1'b0;
  logic              volt_mode = 1'b0;
  logic [NCH-1:0]    int_mask = '1;
  logic              rd_req;
  logic [7:0]        rd_addr;
  logic [STAT_W-1:0] rd_data_q;
  logic              rd_ack_q;
  logic              alert_q;
  logic [1:0]        thermal_alarm_q;
  logic [STAT_W-1:0] d;
  logic [7:0]        tv [4] = '{8'hf0, 8'h3c, 8'h2e, 8'h2d};
  logic [3:0]        t_bit = 4'ha;
  logic [3:0]        t_alarm = 4'h6;
  logic [TEMP_W-1:0] lim_one = 8'h32;
  logic [TEMP_W-1:0] lim_two = 8'h7f;
  int                fails = 0;
  int                n_tests = 0;

  always #50 clk_sys = ~clk_sys;

  lsr_limit_status dut_u (
    .clk_sys                  (clk_sys),
    .rst                      (rst),
    .cmp_valid                (cmp_valid),
    .cmp_chan                 (cmp_chan),
    .cmp_value                (cmp_value),
    .cmp_above_hi             (cmp_above_hi),
    .cmp_below_lo             (cmp_below_lo),
    .remote_temp_two_volt_mode(volt_mode),
    .thermal_limit_one        (lim_one),
    .thermal_limit_two        (lim_two),
    .int_mask                 (int_mask),
    .rd_req                   (rd_req),
    .rd_addr                  (rd_addr),
    .rd_data_q                (rd_data_q),
    .rd_ack_q                 (rd_ack_q),
    .alert_q                  (alert_q),
    .thermal_alarm_q          (thermal_alarm_q)
  );

  lsr_host_model host_u (
    .clk_sys  (clk_sys),
    .rd_req   (rd_req),
    .rd_addr  (rd_addr),
    .rd_data_q(rd_data_q),
    .rd_ack_q (rd_ack_q)
  );

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cmp(input logic [CH_W-1:0] ch, input logic hi, lo,
                     input logic [TEMP_W-1:0] v);
    @(posedge clk_sys);
    cmp_valid    <= 1'b1;
    cmp_chan     <= ch;
    cmp_above_hi <= hi;
    cmp_below_lo <= lo;
    cmp_value    <= v;
    @(posedge clk_sys);
    cmp_valid    <= 1'b0;
  endtask : cmp

  task automatic rd(input logic [7:0] a, exp);
    host_u.read(a, d);
    chk("rd_data_q", d, exp);
  endtask : rd

  task automatic end_of_test();
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #1000000;
    fails++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_STATUS_ONE, STATUS_RST);
    rd(ADDR_STATUS_TWO, STATUS_RST);
    rd(ADDR_STATUS_THREE, STATUS_RST);
    // odd channels above high, even ones below low; fans ignore low
    for (int i = 0; i < 24; i++) begin
      cmp(i[CH_W-1:0], i[0], ~i[0], 8'h00);
    end
    rd(ADDR_STATUS_ONE, 8'hff);
    rd(ADDR_STATUS_TWO, 8'hff);
    rd(ADDR_STATUS_THREE, 8'haa);
    rd(8'h23, RD_UNMAPPED);
    chk("alert_q", {7'h00, alert_q}, 8'h00);
    volt_mode <= 1'b1;
    cmp(CH_REMOTE_TEMP_TWO, 1'b0, 1'b0, 8'h00);
    rd(ADDR_STATUS_ONE, 8'hff);
    cmp(CH_ANALOG_NINE, 1'b0, 1'b0, 8'h00);
    rd(ADDR_STATUS_ONE, 8'hfd);
    int_mask <= 24'hffffef;
    repeat (3) @(posedge clk_sys);
    chk("alert_q", {7'h00, alert_q}, 8'h01);
    rd(ADDR_STATUS_ONE, 8'hfd);
    volt_mode <= 1'b0;
    // refused codes leave bit one alone
    cmp(CH_ANALOG_NINE, 1'b1, 1'b0, 8'h00);
    cmp(5'h19, 1'b1, 1'b1, 8'h00);
    rd(ADDR_STATUS_ONE, 8'hfd);
    // quiet, engage, hold inside hysteresis, release
    for (int c = 0; c < 2; c++) begin
      // each channel must use its own alarm limit
      lim_one <= c[0] ? 8'h7f : 8'h32;
      lim_two <= c[0] ? 8'h32 : 8'h7f;
      for (int k = 0; k < 4; k++) begin
        cmp(c[CH_W-1:0], 1'b0, 1'b0, tv[k]);
        host_u.read(ADDR_STATUS_ONE, d);
        chk("status_bit", {7'h00, d[c]}, {7'h00, t_bit[k]});
        chk("thermal_alarm_q", {7'h00, thermal_alarm_q[c]},
            {7'h00, t_alarm[k]});
      end
    end
    // engage remote two, then a mid-run reset clears everything
    cmp(CH_REMOTE_TEMP_TWO, 1'b0, 1'b0, 8'h3c);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_STATUS_ONE, STATUS_RST);
    chk("thermal_alarm_q", {6'h00, thermal_alarm_q}, 8'h00);
    end_of_test();
  end
endmodule : test_lsr_limit_status
